// >>> hw/dtm_pkg.sv
// constants, types and helper functions of the dual 8-bit interval timer
// ====================================================================
package dtm_pkg;

  // ====================================================================
  // register map, byte addresses on the bus
  localparam logic [7:0] DTM_OFF_SELECT = 8'h00;
  localparam logic [7:0] DTM_OFF_CTRL = 8'h04;
  localparam logic [7:0] DTM_OFF_MATCH_A = 8'h08;
  localparam logic [7:0] DTM_OFF_MATCH_B = 8'h0c;
  localparam logic [7:0] DTM_OFF_COUNT_A = 8'h10;
  localparam logic [7:0] DTM_OFF_COUNT_B = 8'h14;
  localparam logic [7:0] DTM_OFF_STATUS = 8'h18;
  localparam logic [7:0] DTM_OFF_MASK = 8'h1c;
  localparam int DTM_NUM_REGS = 8;

  // ====================================================================
  // field positions and reset values
  localparam int DTM_SEL_A_LSB = 0;
  localparam int DTM_SEL_B_LSB = 4;
  localparam int DTM_CTRL_RUN_A = 0;
  localparam int DTM_CTRL_RUN_B = 1;
  localparam int DTM_CTRL_MODE = 2;
  localparam logic [7:0] DTM_SELECT_RST = 8'h00;
  localparam logic [2:0] DTM_CTRL_RST = 3'h0;
  localparam logic [7:0] DTM_MATCH_RST = 8'h00;
  localparam logic [1:0] DTM_STATUS_RST = 2'h0;
  localparam logic [1:0] DTM_MASK_RST = 2'h0;

  // ====================================================================
  // source codes and prescaler
  localparam logic [3:0] DTM_CODE_FALL = 4'h0;
  localparam logic [3:0] DTM_CODE_RISE = 4'h1;
  localparam logic [3:0] DTM_CODE_INT_LO = 4'h6;
  localparam logic [3:0] DTM_CODE_SLOWEST = 4'hf;
  localparam logic [3:0] DTM_CODE_EXP_BIAS = 4'h5;
  localparam logic [3:0] DTM_EXP_SLOW_FAST = 4'hb;
  localparam logic [3:0] DTM_EXP_SLOW_HALF = 4'hc;
  localparam int DTM_PRESC_W = 13;
  localparam logic [1:0] DTM_RESP_OKAY = 2'h0;
  localparam logic [1:0] DTM_RESP_SLVERR = 2'h2;

  // ====================================================================
  // per-channel configuration bundle
  typedef struct packed {
    logic run;
    logic [7:0] match;
  } dtm_chan_cfg_t;

  // one-hot register hit for a byte address
  function automatic logic [DTM_NUM_REGS-1:0] dtm_decode(input logic [7:0] addr);
    dtm_decode = '0;
    if (addr[7:5] == 3'h0) begin
      dtm_decode[addr[4:2]] = 1'b1;
    end
  endfunction : dtm_decode

  // power-of-two exponent of an internal source code
  function automatic logic [3:0] dtm_div_exp(input logic [3:0] code, input logic mode);
    if (code == DTM_CODE_SLOWEST) begin
      dtm_div_exp = mode ? DTM_EXP_SLOW_FAST : DTM_EXP_SLOW_HALF;
    end else begin
      dtm_div_exp = code - DTM_CODE_EXP_BIAS + {3'h0, ~mode};
    end
  endfunction : dtm_div_exp

endpackage : dtm_pkg

// >>> hw/dtm_channel.sv
// one 8-bit interval counter with clear on match
`timescale 1ns/1ps
module dtm_channel
  import dtm_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // configuration and count enable
  input wire dtm_chan_cfg_t i_cfg,
  input wire logic i_tick,
  // state
  output logic [7:0] o_count,
  output logic o_match
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic match_r;
  logic hit;

  // ====================================================================
  // next count: hold at zero when stopped, wrap on match
  assign hit = i_cfg.run && i_tick && (count_r == i_cfg.match);
  assign count_nxt = !i_cfg.run ? 8'h00 :
                     hit ? 8'h00 :
                     i_tick ? count_r + 8'h01 : count_r;

  // counter and match pulse flops
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r <= 8'h00;
      match_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      match_r <= hit;
    end
  end

  assign o_count = count_r;
  assign o_match = match_r;

  // ====================================================================
  // checks
  a_clear_on_match: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_cfg.run && i_tick && count_r == i_cfg.match |=> count_r == 8'h00 && match_r)
    else $error("counter not cleared with request on match");
  a_hold_stopped: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_cfg.run |=> count_r == 8'h00 && !match_r)
    else $error("stopped counter not held at zero");
  a_count_step: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_cfg.run && i_tick && count_r != i_cfg.match |=> count_r == $past(count_r) + 8'h01)
    else $error("counter did not advance by one");
  a_idle_stable: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_cfg.run && !i_tick |=> count_r == $past(count_r) && !match_r)
    else $error("counter moved without a count enable");
  c_wrap_ff: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    i_cfg.run && i_tick && count_r == 8'hff && i_cfg.match == 8'hff);

endmodule : dtm_channel

// >>> hw/dtm_timer.sv
// top of the dual 8-bit interval timer with axi4-lite register slave
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module dtm_timer
  import dtm_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // axi4-lite write address
  input wire logic i_awvalid,
  input wire logic [7:0] i_awaddr,
  output logic o_awready,
  // axi4-lite write data
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  // axi4-lite write response
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // axi4-lite read address
  input wire logic i_arvalid,
  input wire logic [7:0] i_araddr,
  output logic o_arready,
  // axi4-lite read data
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready,
  // external count inputs
  input wire logic i_ext_count_in_a,
  input wire logic i_ext_count_in_b,
  // interrupt requests
  output logic o_match_irq_a,
  output logic o_match_irq_b,
  output logic o_irq
);

  // ====================================================================
  // register state
  logic [7:0] count_source_select_r;
  logic [2:0] ctrl_r;
  logic [7:0] match_value_a_r;
  logic [7:0] match_value_b_r;
  logic [1:0] status_r;
  logic [1:0] status_nxt;
  logic [1:0] mask_r;
  logic irq_r;

  // bus handshake state
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // source logic
  logic [DTM_PRESC_W-1:0] presc_r;
  logic ext_a_prev_r;
  logic ext_b_prev_r;
  logic [7:0] count_a;
  logic [7:0] count_b;
  logic match_a;
  logic match_b;

  // ====================================================================
  // bus decode and handshake terms
  logic aw_take;
  logic w_take;
  logic aw_held_nxt;
  logic w_held_nxt;
  logic do_write;
  logic b_done;
  logic bvalid_nxt;
  logic ar_take;
  logic r_done;
  logic [DTM_NUM_REGS-1:0] wr_hit;
  logic [DTM_NUM_REGS-1:0] rd_hit;
  logic wr_lane0;
  logic [31:0] rd_mux;

  assign aw_take = i_awvalid && awready_r;
  assign w_take = i_wvalid && wready_r;
  assign b_done = bvalid_r && i_bready;
  assign aw_held_nxt = (aw_held_r || aw_take) && !do_write;
  assign w_held_nxt = (w_held_r || w_take) && !do_write;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign bvalid_nxt = do_write || (bvalid_r && !i_bready);
  assign ar_take = i_arvalid && arready_r;
  assign r_done = rvalid_r && i_rready;
  assign wr_hit = do_write ? dtm_decode(aw_addr_r) : '0;
  assign rd_hit = dtm_decode(i_araddr);
  assign wr_lane0 = w_strb_r[0];

  // read data selection
  assign rd_mux = rd_hit[DTM_OFF_SELECT[4:2]] ? {24'h0, count_source_select_r} :
                  rd_hit[DTM_OFF_CTRL[4:2]] ? {29'h0, ctrl_r} :
                  rd_hit[DTM_OFF_MATCH_A[4:2]] ? {24'h0, match_value_a_r} :
                  rd_hit[DTM_OFF_MATCH_B[4:2]] ? {24'h0, match_value_b_r} :
                  rd_hit[DTM_OFF_COUNT_A[4:2]] ? {24'h0, count_a} :
                  rd_hit[DTM_OFF_COUNT_B[4:2]] ? {24'h0, count_b} :
                  rd_hit[DTM_OFF_STATUS[4:2]] ? {30'h0, status_r} :
                  rd_hit[DTM_OFF_MASK[4:2]] ? {30'h0, mask_r} : 32'h0;

  // write channel holding and response
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= DTM_RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      if (aw_take) begin
        aw_addr_r <= i_awaddr;
      end
      if (w_take) begin
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
      awready_r <= !aw_held_nxt && !bvalid_nxt;
      wready_r <= !w_held_nxt && !bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (do_write) begin
        bresp_r <= (|dtm_decode(aw_addr_r)) ? DTM_RESP_OKAY : DTM_RESP_SLVERR;
      end
    end
  end

  // read channel
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= DTM_RESP_OKAY;
    end else begin
      arready_r <= !(rvalid_r && !r_done) && !ar_take;
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= (|rd_hit) ? DTM_RESP_OKAY : DTM_RESP_SLVERR;
      end else if (r_done) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ====================================================================
  // software registers, low byte lane only
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_source_select_r <= DTM_SELECT_RST;
      ctrl_r <= DTM_CTRL_RST;
      match_value_a_r <= DTM_MATCH_RST;
      match_value_b_r <= DTM_MATCH_RST;
      mask_r <= DTM_MASK_RST;
    end else if (wr_lane0) begin
      if (wr_hit[DTM_OFF_SELECT[4:2]]) begin
        count_source_select_r <= w_data_r[7:0];
      end
      if (wr_hit[DTM_OFF_CTRL[4:2]]) begin
        ctrl_r <= w_data_r[2:0];
      end
      if (wr_hit[DTM_OFF_MATCH_A[4:2]]) begin
        match_value_a_r <= w_data_r[7:0];
      end
      if (wr_hit[DTM_OFF_MATCH_B[4:2]]) begin
        match_value_b_r <= w_data_r[7:0];
      end
      if (wr_hit[DTM_OFF_MASK[4:2]]) begin
        mask_r <= w_data_r[1:0];
      end
    end
  end

  // ====================================================================
  // free prescaler and pin edge history
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_r <= '0;
      ext_a_prev_r <= 1'b0;
      ext_b_prev_r <= 1'b0;
    end else begin
      presc_r <= presc_r + 13'h1;
      ext_a_prev_r <= i_ext_count_in_a;
      ext_b_prev_r <= i_ext_count_in_b;
    end
  end

  // ====================================================================
  // per-channel source selection and counter
  logic osc_halving_mode;
  logic [1:0] ext_now;
  logic [1:0] ext_prev;
  logic [1:0] ch_tick;
  logic [1:0] ch_run;
  logic [7:0] ch_match [2];
  logic [7:0] ch_count [2];
  logic [1:0] ch_hit;
  logic [3:0] ch_sel [2];

  assign osc_halving_mode = ctrl_r[DTM_CTRL_MODE];
  assign ext_now = {i_ext_count_in_b, i_ext_count_in_a};
  assign ext_prev = {ext_b_prev_r, ext_a_prev_r};
  assign ch_sel[0] = count_source_select_r[DTM_SEL_A_LSB +: 4];
  assign ch_sel[1] = count_source_select_r[DTM_SEL_B_LSB +: 4];
  assign ch_run = {ctrl_r[DTM_CTRL_RUN_B], ctrl_r[DTM_CTRL_RUN_A]};
  assign ch_match[0] = match_value_a_r;
  assign ch_match[1] = match_value_b_r;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_chan
      logic [3:0] exp_w;
      logic [DTM_PRESC_W-1:0] mask_w;
      logic int_tick;
      logic fall_tick;
      logic rise_tick;
      dtm_chan_cfg_t cfg;

      // internal rate: low exp bits of prescaler all ones
      assign exp_w = dtm_div_exp(ch_sel[g], osc_halving_mode);
      assign mask_w = (13'h1 << exp_w) - 13'h1;
      assign int_tick = (ch_sel[g] >= DTM_CODE_INT_LO) && ((presc_r & mask_w) == mask_w);
      assign fall_tick = (ch_sel[g] == DTM_CODE_FALL) && ext_prev[g] && !ext_now[g];
      assign rise_tick = (ch_sel[g] == DTM_CODE_RISE) && !ext_prev[g] && ext_now[g];
      assign ch_tick[g] = int_tick || fall_tick || rise_tick;
      assign cfg = '{run: ch_run[g], match: ch_match[g]};

      dtm_channel u_chan (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_cfg(cfg),
        .i_tick(ch_tick[g]),
        .o_count(ch_count[g]),
        .o_match(ch_hit[g])
      );
    end
  endgenerate

  assign count_a = ch_count[0];
  assign count_b = ch_count[1];
  assign match_a = ch_hit[0];
  assign match_b = ch_hit[1];

  // ====================================================================
  // sticky status, cleared by reading it; a new match wins over the clear
  logic status_rd;

  assign status_rd = ar_take && rd_hit[DTM_OFF_STATUS[4:2]];
  assign status_nxt = (status_r & ~{2{status_rd}}) | {match_b, match_a};

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_r <= DTM_STATUS_RST;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // outputs
  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_match_irq_a = match_a;
  assign o_match_irq_b = match_b;
  assign o_irq = irq_r;

  // ====================================================================
  // checks
  a_reset_select: assert property (@(posedge i_clock)
    !i_rst_n |-> count_source_select_r == 8'h00)
    else $error("select register not zero in reset");
  a_fall_edge_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ch_sel[0] == 4'h0 && $fell(i_ext_count_in_a) |-> ch_tick[0])
    else $error("falling edge not counted on channel a");
  a_rise_edge_b: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ch_sel[1] == 4'h1 && $rose(i_ext_count_in_b) |-> ch_tick[1])
    else $error("rising edge not counted on channel b");
  // rate tied to the prescaler phase each cycle, so a mode write cannot trip it
  a_div_two: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ch_sel[0] == 4'h6 && osc_halving_mode |-> ch_tick[0] == presc_r[0])
    else $error("fastest rate is not every second cycle");
  a_div_four: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ch_sel[0] == 4'h6 && !osc_halving_mode |-> ch_tick[0] == (presc_r[1:0] == 2'h3))
    else $error("halved fastest rate is not every fourth cycle");
  a_div_slowest: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ch_sel[1] == 4'hf && ch_tick[1] |-> presc_r[10:0] == 11'h7ff &&
    (osc_halving_mode || presc_r[11]))
    else $error("slowest rate not on the right prescaler phase");
  a_tick_single: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ch_sel[0] >= 4'h6 && ch_tick[0] && $stable(count_source_select_r) |=> !ch_tick[0])
    else $error("internal count enable longer than one cycle");
  a_irq_level: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    match_a && mask_r[0] |=> o_irq && status_r[0])
    else $error("unmasked match did not raise the interrupt");
  c_match_a: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_match_irq_a);
  c_status_read: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    status_rd && match_a);
  c_ext_b: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    ch_sel[1] == 4'h0 && ch_tick[1]);

endmodule : dtm_timer

// >>> verif/dtm_timer_tb.sv
// self-checking testbench of the dual 8-bit interval timer
`timescale 1ns/1ps
module dtm_timer_tb
  import dtm_pkg::*;
;
  // ====================================================================
  // signals
  logic i_clock, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic i_ext_count_in_a, i_ext_count_in_b, o_match_irq_a, o_match_irq_b, o_irq;
  int fails = 0;
  int tests_run = 0;
  logic [31:0] d;
  logic [1:0] r;
  int n;
  // one row: channel, source code, mode bit, match value, cycles between pulses
  typedef struct {logic ch; logic [3:0] code; logic mode; logic [7:0] match; int period;} dtm_row_t;
  dtm_row_t rows [21] = '{
    '{1'h0, 4'h6, 1'h1, 8'h03, 8}, '{1'h0, 4'h6, 1'h0, 8'h02, 12}, '{1'h0, 4'h7, 1'h1, 8'h00, 4},
    '{1'h0, 4'h7, 1'h0, 8'h00, 8}, '{1'h1, 4'h8, 1'h1, 8'h00, 8}, '{1'h1, 4'h8, 1'h0, 8'h00, 16},
    '{1'h1, 4'h9, 1'h1, 8'h00, 16}, '{1'h1, 4'h9, 1'h0, 8'h01, 64}, '{1'h0, 4'ha, 1'h1, 8'h00, 32},
    '{1'h0, 4'ha, 1'h0, 8'h00, 64}, '{1'h1, 4'hb, 1'h1, 8'h00, 64}, '{1'h1, 4'hb, 1'h0, 8'h00, 128},
    '{1'h0, 4'hc, 1'h1, 8'h00, 128}, '{1'h0, 4'hc, 1'h0, 8'h00, 256},
    '{1'h1, 4'hd, 1'h1, 8'h00, 256}, '{1'h1, 4'hd, 1'h0, 8'h00, 512},
    '{1'h0, 4'he, 1'h1, 8'h00, 512}, '{1'h0, 4'he, 1'h0, 8'h00, 1024},
    '{1'h1, 4'hf, 1'h1, 8'h00, 2048}, '{1'h0, 4'hf, 1'h0, 8'h00, 4096},
    '{1'h1, 4'h6, 1'h1, 8'hff, 512}};

  // ====================================================================
  // design under test
  dtm_timer u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
    .i_awaddr(i_awaddr), .o_awready(o_awready), .i_wvalid(i_wvalid), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
    .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr), .o_arready(o_arready),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp), .i_rready(i_rready),
    .i_ext_count_in_a(i_ext_count_in_a), .i_ext_count_in_b(i_ext_count_in_b),
    .o_match_irq_a(o_match_irq_a), .o_match_irq_b(o_match_irq_b), .o_irq(o_irq));

  // clock, 25 ns period
  initial begin
    i_clock = 1'h0;
    forever #12.5 i_clock = ~i_clock;
  end

  // ====================================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask : chk

  // one axi4-lite write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    int k;
    k = 0;
    @(posedge i_clock);
    i_awaddr <= a;
    i_wdata <= dat;
    i_wstrb <= 4'hf;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(posedge i_clock);
      if (i_awvalid && o_awready) i_awvalid <= 1'h0;
      if (i_wvalid && o_wready) i_wvalid <= 1'h0;
      k++;
    end while (!(o_bvalid === 1'h1) && k < 100);
    rsp = o_bresp;
    i_bready <= 1'h0;
    if (k >= 100) fails++;
  endtask : axw

  // one axi4-lite read
  task automatic axr(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    int k;
    k = 0;
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      @(posedge i_clock);
      if (i_arvalid && o_arready) i_arvalid <= 1'h0;
      k++;
    end while (!(o_rvalid === 1'h1) && k < 100);
    dat = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'h0;
    if (k >= 100) fails++;
  endtask : axr

  // cycles until the next match pulse of one channel
  task automatic wait_pulse(input logic ch, output int cyc);
    cyc = 0;
    do begin
      @(negedge i_clock);
      cyc++;
    end while (!((ch ? o_match_irq_b : o_match_irq_a) === 1'h1) && cyc < 20000);
  endtask : wait_pulse

  // every mapped register reads zero after reset
  task automatic rst_chk();
    for (int a = 0; a < 32; a += 4) begin
      axr(8'(a), d, r);
      chk("reset value", d, 32'h0);
      chk("reset resp", {30'h0, r}, {30'h0, DTM_RESP_OKAY});
    end
    $display("reset values done");
  endtask : rst_chk

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // watchdog, well beyond the expected run length
  initial begin
    #(90000 * 25);
    fails++;
    summarize();
  end

  // ====================================================================
  // main sequence
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    {i_ext_count_in_a, i_ext_count_in_b} = 2'h0;
    i_rst_n = 1'h0;
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'h1;
    rst_chk();
    // table of source codes, modes and match values
    foreach (rows[i]) begin
      axw(DTM_OFF_CTRL, 32'h0, r); // stop first, only defined codes follow
      axw(DTM_OFF_SELECT, rows[i].ch ? {24'h0, rows[i].code, 4'h0} : {28'h0, rows[i].code}, r);
      axw(rows[i].ch ? DTM_OFF_MATCH_B : DTM_OFF_MATCH_A, {24'h0, rows[i].match}, r);
      axw(DTM_OFF_CTRL, {29'h0, rows[i].mode, rows[i].ch, ~rows[i].ch}, r);
      wait_pulse(rows[i].ch, n);
      wait_pulse(rows[i].ch, n);
      chk("period", n, rows[i].period);
      $display("row %0d done", i);
    end
    // masked status keeps the line low, unmasking raises it, a read clears it
    axw(DTM_OFF_CTRL, 32'h0, r);
    @(negedge i_clock);
    chk("irq masked", {31'h0, o_irq}, 32'h0);
    axw(DTM_OFF_MASK, 32'h3, r);
    repeat (2) @(negedge i_clock);
    chk("irq unmasked", {31'h0, o_irq}, 32'h1);
    axr(DTM_OFF_STATUS, d, r);
    chk("status", d, 32'h3);
    axr(DTM_OFF_STATUS, d, r);
    chk("status cleared", d, 32'h0);
    repeat (2) @(negedge i_clock);
    chk("irq cleared", {31'h0, o_irq}, 32'h0);
    // a live match on channel a (match value 00) raises the unmasked line
    axw(DTM_OFF_SELECT, 32'h06, r);
    axw(DTM_OFF_CTRL, 32'h5, r);
    wait_pulse(1'h0, n);
    @(negedge i_clock);
    chk("irq on match", {31'h0, o_irq}, 32'h1);
    axw(DTM_OFF_CTRL, 32'h0, r);
    $display("interrupt test done");
    // stopping a channel holds its counter at zero
    axw(DTM_OFF_MATCH_A, 32'hff, r);
    axw(DTM_OFF_SELECT, 32'h06, r);
    axw(DTM_OFF_CTRL, 32'h5, r);
    repeat (40) @(posedge i_clock);
    axr(DTM_OFF_COUNT_A, d, r);
    chk("running count", {31'h0, d != 32'h0}, 32'h1);
    axw(DTM_OFF_CTRL, 32'h0, r);
    axr(DTM_OFF_COUNT_A, d, r);
    chk("stopped count", d, 32'h0);
    $display("run control test done");
    // pin edges, 9 toggles a pass; pass 0 from low: a falling 4, b rising 5;
    // pass 1 from high with codes swapped: a rising 4, b falling 5
    axw(DTM_OFF_MATCH_B, 32'hff, r);
    for (int p = 0; p < 2; p++) begin
      axw(DTM_OFF_CTRL, 32'h0, r);
      axw(DTM_OFF_SELECT, p ? 32'h01 : 32'h10, r);
      axw(DTM_OFF_CTRL, 32'h3, r);
      repeat (9) begin
        @(posedge i_clock);
        i_ext_count_in_a <= ~i_ext_count_in_a;
        i_ext_count_in_b <= ~i_ext_count_in_b;
        repeat (3) @(posedge i_clock);
      end
      repeat (4) @(posedge i_clock);
      axr(DTM_OFF_COUNT_A, d, r);
      chk("edges a", d, 32'h4);
      axr(DTM_OFF_COUNT_B, d, r);
      chk("edges b", d, 32'h5);
    end
    $display("pin edge test done");
    // unmapped addresses answer with an error
    axw(8'h20, 32'h1, r);
    chk("unmapped write", {30'h0, r}, {30'h0, DTM_RESP_SLVERR});
    axr(8'h40, d, r);
    chk("unmapped read", {30'h0, r}, {30'h0, DTM_RESP_SLVERR});
    chk("unmapped data", d, 32'h0);
    $display("unmapped test done");
    // second reset in mid-run
    axw(DTM_OFF_CTRL, 32'h0, r);
    axw(DTM_OFF_SELECT, 32'h76, r);
    axw(DTM_OFF_CTRL, 32'h7, r);
    @(posedge i_clock);
    i_rst_n <= 1'h0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'h1;
    rst_chk();
    summarize();
  end

endmodule : dtm_timer_tb
